// file: core_timer_pkg.sv
// Constants shared by the core timer and watchdog unit
// Overview of operation
// - Low time base word reads at number 0x10C, privileged write at 0x11C.
// - High time base word reads at number 0x10D, privileged write at 0x11D.
// - Watchdog period code picks 2^17, 2^21, 2^25 or 2^29 clocks.
// - Watchdog reset kind picks none, core, chip or system reset on expiry.
// - Reset kind resets to zero; writes may set its bits, never clear them.
// - Watchdog interrupt enable gates the watchdog interrupt.
// - Interval interrupt enable gates the programmable interval timer interrupt.
// - Fixed period code picks 2^9, 2^13, 2^17 or 2^21 clocks.
// - Fixed interrupt enable gates the fixed interval timer interrupt.
// - Auto reload enable reloads the interval timer; off after reset.
// - Watchdog event first sets next arm bit, else follows the pending bit.
// - Status bit 1 shows a pending watchdog interrupt.
// - Status bits 2:3 record which reset the watchdog forced.
// - Status bit 4 shows a pending interval timer interrupt.
// - Status bit 5 shows a pending fixed timer interrupt.
// - Interval timer register holds clocks left until its event.
// - Critical interrupt enable gates the watchdog interrupt.
// - Noncritical interrupt enable gates interval and fixed timer interrupts.
package core_timer_pkg;

   // Register numbers
   localparam logic [9:0] TB_LOW_READ_NUM = 10'h10c;
   localparam logic [9:0] TB_HIGH_READ_NUM = 10'h10d;
   localparam logic [9:0] TB_LOW_WRITE_NUM = 10'h11c;
   localparam logic [9:0] TB_HIGH_WRITE_NUM = 10'h11d;
   localparam logic [9:0] TIMER_STATUS_NUM = 10'h3d8;
   localparam logic [9:0] TIMER_CONTROL_NUM = 10'h3da;
   localparam logic [9:0] INTERVAL_TIMER_NUM = 10'h3db;

   // Control field positions (bit 0 of the word is the most significant)
   localparam int CTL_WD_PERIOD_HI = 31;
   localparam int CTL_WD_PERIOD_LO = 30;
   localparam int CTL_WD_RESET_HI = 29;
   localparam int CTL_WD_RESET_LO = 28;
   localparam int CTL_WD_IRQ_EN = 27;
   localparam int CTL_INTERVAL_IRQ_EN = 26;
   localparam int CTL_FIXED_PERIOD_HI = 25;
   localparam int CTL_FIXED_PERIOD_LO = 24;
   localparam int CTL_FIXED_IRQ_EN = 23;
   localparam int CTL_AUTO_RELOAD = 22;

   // Status field positions
   localparam int STS_NEXT_ARM = 31;
   localparam int STS_WD_PENDING = 30;
   localparam int STS_WD_CAUSE_HI = 29;
   localparam int STS_WD_CAUSE_LO = 28;
   localparam int STS_INTERVAL_PENDING = 27;
   localparam int STS_FIXED_PENDING = 26;

   // Period exponents: exponent = base + step * code
   localparam int WD_PERIOD_BASE_EXP = 17;
   localparam int FIXED_PERIOD_BASE_EXP = 9;
   localparam int PERIOD_EXP_STEP = 4;

   // Reset values and constants
   localparam logic [1:0] RESET_KIND_NONE = 2'h0;
   localparam logic [1:0] PERIOD_CODE_RESET = 2'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0;
   localparam logic [31:0] INTERVAL_LAST = 32'h1;
   localparam logic [63:0] TB_STEP = 64'h1;

endpackage

// file: timebase_counter.sv
// 64-bit time base counter with separate word loads
`timescale 1ns/1ps
module timebase_counter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Word loads
   input wire logic load_low,
   input wire logic load_high,
   input wire logic [31:0] load_data,
   // Count
   output logic [63:0] count
);

   logic [63:0] next_count;

   // Advance by one; a load replaces its word of the advanced value
   always_comb begin
      next_count = count + core_timer_pkg::TB_STEP;
      if (load_low) begin
         next_count[31:0] = load_data;
      end
      if (load_high) begin
         next_count[63:32] = load_data;
      end
   end

   // Count register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 64'h0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// file: core_timer_watchdog_unit.sv
// Timer facility: time base, watchdog, interval and fixed timers
`timescale 1ns/1ps
module core_timer_watchdog_unit (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Special register access
   input wire logic [9:0] reg_num,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic supervisor,
   output logic [31:0] rd_data,
   output logic rd_valid,
   // Machine state enables
   input wire logic crit_irq_enable,
   input wire logic noncritical_irq_enable,
   // Interrupts and reset requests
   output logic watchdog_irq,
   output logic interval_irq,
   output logic fixed_irq,
   output logic [1:0] watchdog_reset_req
);

   // Picks the time base bit whose rising edge ends one period
   function automatic logic period_bit(input logic [63:0] tb, input logic [1:0] code,
                                       input int base_exp);
      int idx;
      idx = base_exp - 1 + core_timer_pkg::PERIOD_EXP_STEP * int'(code);
      period_bit = tb[idx];
   endfunction

   logic [63:0] tb_count;
   logic wr_ok;
   logic wr_tb_low;
   logic wr_tb_high;
   logic wr_status;
   logic wr_control;
   logic wr_interval;

   // Control fields
   logic [1:0] watchdog_period_select;
   logic [1:0] watchdog_reset_kind;
   logic watchdog_irq_enable;
   logic interval_irq_enable;
   logic [1:0] fixed_period_select;
   logic fixed_irq_enable;
   logic auto_reload;
   logic [1:0] next_watchdog_period_select;
   logic [1:0] next_watchdog_reset_kind;
   logic next_watchdog_irq_enable;
   logic next_interval_irq_enable;
   logic [1:0] next_fixed_period_select;
   logic next_fixed_irq_enable;
   logic next_auto_reload;

   // Status fields
   logic next_watchdog_arm;
   logic watchdog_irq_pending;
   logic [1:0] watchdog_reset_cause;
   logic interval_irq_pending;
   logic fixed_irq_pending;
   logic next_next_watchdog_arm;
   logic next_watchdog_irq_pending;
   logic [1:0] next_watchdog_reset_cause;
   logic next_interval_irq_pending;
   logic next_fixed_irq_pending;

   // Timers and edge history
   logic [31:0] programmable_interval_timer;
   logic [31:0] interval_reload;
   logic [31:0] next_programmable_interval_timer;
   logic [31:0] next_interval_reload;
   logic wd_bit_prev;
   logic fixed_bit_prev;
   logic wd_bit;
   logic fixed_bit;
   logic wd_event;
   logic fixed_event;
   logic interval_event;

   // Outputs
   logic [31:0] next_rd_data;
   logic next_watchdog_irq;
   logic next_interval_irq;
   logic next_fixed_irq;
   logic [1:0] next_watchdog_reset_req;

   // Write decode; register writes need supervisor state
   assign wr_ok = reg_wr && supervisor;
   assign wr_tb_low = wr_ok && (reg_num == core_timer_pkg::TB_LOW_WRITE_NUM);
   assign wr_tb_high = wr_ok && (reg_num == core_timer_pkg::TB_HIGH_WRITE_NUM);
   assign wr_status = wr_ok && (reg_num == core_timer_pkg::TIMER_STATUS_NUM);
   assign wr_control = wr_ok && (reg_num == core_timer_pkg::TIMER_CONTROL_NUM);
   assign wr_interval = wr_ok && (reg_num == core_timer_pkg::INTERVAL_TIMER_NUM);

   timebase_counter u_timebase (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .load_low(wr_tb_low),
      .load_high(wr_tb_high),
      .load_data(reg_wdata),
      .count(tb_count)
   );

   // Period events on rising edges of the selected time base bits
   assign wd_bit = period_bit(tb_count, watchdog_period_select,
                              core_timer_pkg::WD_PERIOD_BASE_EXP);
   assign fixed_bit = period_bit(tb_count, fixed_period_select,
                                 core_timer_pkg::FIXED_PERIOD_BASE_EXP);
   assign wd_event = wd_bit && !wd_bit_prev;
   assign fixed_event = fixed_bit && !fixed_bit_prev;
   assign interval_event = !wr_interval
      && (programmable_interval_timer == core_timer_pkg::INTERVAL_LAST);

   // Control register next values
   always_comb begin
      next_watchdog_period_select = watchdog_period_select;
      next_watchdog_reset_kind = watchdog_reset_kind;
      next_watchdog_irq_enable = watchdog_irq_enable;
      next_interval_irq_enable = interval_irq_enable;
      next_fixed_period_select = fixed_period_select;
      next_fixed_irq_enable = fixed_irq_enable;
      next_auto_reload = auto_reload;
      if (wr_control) begin
         next_watchdog_period_select =
            reg_wdata[core_timer_pkg::CTL_WD_PERIOD_HI:core_timer_pkg::CTL_WD_PERIOD_LO];
         // Reset kind bits only accumulate
         next_watchdog_reset_kind = watchdog_reset_kind
            | reg_wdata[core_timer_pkg::CTL_WD_RESET_HI:core_timer_pkg::CTL_WD_RESET_LO];
         next_watchdog_irq_enable = reg_wdata[core_timer_pkg::CTL_WD_IRQ_EN];
         next_interval_irq_enable = reg_wdata[core_timer_pkg::CTL_INTERVAL_IRQ_EN];
         next_fixed_period_select =
            reg_wdata[core_timer_pkg::CTL_FIXED_PERIOD_HI:core_timer_pkg::CTL_FIXED_PERIOD_LO];
         next_fixed_irq_enable = reg_wdata[core_timer_pkg::CTL_FIXED_IRQ_EN];
         next_auto_reload = reg_wdata[core_timer_pkg::CTL_AUTO_RELOAD];
      end
   end

   // Control registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_period_select <= core_timer_pkg::PERIOD_CODE_RESET;
         watchdog_reset_kind <= core_timer_pkg::RESET_KIND_NONE;
         watchdog_irq_enable <= 1'b0;
         interval_irq_enable <= 1'b0;
         fixed_period_select <= core_timer_pkg::PERIOD_CODE_RESET;
         fixed_irq_enable <= 1'b0;
         auto_reload <= 1'b0;
      end else begin
         watchdog_period_select <= next_watchdog_period_select;
         watchdog_reset_kind <= next_watchdog_reset_kind;
         watchdog_irq_enable <= next_watchdog_irq_enable;
         interval_irq_enable <= next_interval_irq_enable;
         fixed_period_select <= next_fixed_period_select;
         fixed_irq_enable <= next_fixed_irq_enable;
         auto_reload <= next_auto_reload;
      end
   end

   // Status next values: write-one clears first, hardware sets win
   always_comb begin
      next_next_watchdog_arm = next_watchdog_arm;
      next_watchdog_irq_pending = watchdog_irq_pending;
      next_watchdog_reset_cause = watchdog_reset_cause;
      next_interval_irq_pending = interval_irq_pending;
      next_fixed_irq_pending = fixed_irq_pending;
      next_watchdog_reset_req = core_timer_pkg::RESET_KIND_NONE;
      if (wr_status) begin
         // Clearing the arm bit is how software stops escalation
         if (reg_wdata[core_timer_pkg::STS_NEXT_ARM]) begin
            next_next_watchdog_arm = 1'b0;
         end
         if (reg_wdata[core_timer_pkg::STS_WD_PENDING]) begin
            next_watchdog_irq_pending = 1'b0;
         end
         next_watchdog_reset_cause = watchdog_reset_cause
            & ~reg_wdata[core_timer_pkg::STS_WD_CAUSE_HI:core_timer_pkg::STS_WD_CAUSE_LO];
         if (reg_wdata[core_timer_pkg::STS_INTERVAL_PENDING]) begin
            next_interval_irq_pending = 1'b0;
         end
         if (reg_wdata[core_timer_pkg::STS_FIXED_PENDING]) begin
            next_fixed_irq_pending = 1'b0;
         end
      end
      // Watchdog escalation: arm, then interrupt, then reset
      if (wd_event) begin
         if (!next_watchdog_arm) begin
            next_next_watchdog_arm = 1'b1;
         end else if (!watchdog_irq_pending) begin
            next_watchdog_irq_pending = 1'b1;
         end else begin
            next_watchdog_reset_cause = watchdog_reset_kind;
            next_watchdog_reset_req = watchdog_reset_kind;
         end
      end
      if (interval_event) begin
         next_interval_irq_pending = 1'b1;
      end
      if (fixed_event) begin
         next_fixed_irq_pending = 1'b1;
      end
   end

   // Status registers and reset request pulse
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         next_watchdog_arm <= 1'b0;
         watchdog_irq_pending <= 1'b0;
         watchdog_reset_cause <= core_timer_pkg::RESET_KIND_NONE;
         interval_irq_pending <= 1'b0;
         fixed_irq_pending <= 1'b0;
         watchdog_reset_req <= core_timer_pkg::RESET_KIND_NONE;
      end else begin
         next_watchdog_arm <= next_next_watchdog_arm;
         watchdog_irq_pending <= next_watchdog_irq_pending;
         watchdog_reset_cause <= next_watchdog_reset_cause;
         interval_irq_pending <= next_interval_irq_pending;
         fixed_irq_pending <= next_fixed_irq_pending;
         watchdog_reset_req <= next_watchdog_reset_req;
      end
   end

   // Interval timer counts down to zero, optionally reloading
   always_comb begin
      next_interval_reload = interval_reload;
      next_programmable_interval_timer = programmable_interval_timer;
      if (wr_interval) begin
         next_interval_reload = reg_wdata;
         next_programmable_interval_timer = reg_wdata;
      end else if (interval_event && auto_reload) begin
         next_programmable_interval_timer = interval_reload;
      end else if (programmable_interval_timer != core_timer_pkg::WORD_ZERO) begin
         next_programmable_interval_timer =
            programmable_interval_timer - core_timer_pkg::INTERVAL_LAST;
      end
   end

   // Interval timer registers and period edge history
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         programmable_interval_timer <= core_timer_pkg::WORD_ZERO;
         interval_reload <= core_timer_pkg::WORD_ZERO;
         wd_bit_prev <= 1'b0;
         fixed_bit_prev <= 1'b0;
      end else begin
         programmable_interval_timer <= next_programmable_interval_timer;
         interval_reload <= next_interval_reload;
         wd_bit_prev <= wd_bit;
         fixed_bit_prev <= fixed_bit;
      end
   end

   // Read data and gated interrupt outputs
   always_comb begin
      next_rd_data = core_timer_pkg::WORD_ZERO;
      case (reg_num)
         core_timer_pkg::TB_LOW_READ_NUM: begin
            next_rd_data = tb_count[31:0];
         end
         core_timer_pkg::TB_HIGH_READ_NUM: begin
            next_rd_data = tb_count[63:32];
         end
         core_timer_pkg::TIMER_STATUS_NUM: begin
            next_rd_data[core_timer_pkg::STS_NEXT_ARM] = next_watchdog_arm;
            next_rd_data[core_timer_pkg::STS_WD_PENDING] = watchdog_irq_pending;
            next_rd_data[core_timer_pkg::STS_WD_CAUSE_HI:core_timer_pkg::STS_WD_CAUSE_LO] =
               watchdog_reset_cause;
            next_rd_data[core_timer_pkg::STS_INTERVAL_PENDING] = interval_irq_pending;
            next_rd_data[core_timer_pkg::STS_FIXED_PENDING] = fixed_irq_pending;
         end
         core_timer_pkg::TIMER_CONTROL_NUM: begin
            next_rd_data[core_timer_pkg::CTL_WD_PERIOD_HI:core_timer_pkg::CTL_WD_PERIOD_LO] =
               watchdog_period_select;
            next_rd_data[core_timer_pkg::CTL_WD_RESET_HI:core_timer_pkg::CTL_WD_RESET_LO] =
               watchdog_reset_kind;
            next_rd_data[core_timer_pkg::CTL_WD_IRQ_EN] = watchdog_irq_enable;
            next_rd_data[core_timer_pkg::CTL_INTERVAL_IRQ_EN] = interval_irq_enable;
            next_rd_data[core_timer_pkg::CTL_FIXED_PERIOD_HI:core_timer_pkg::CTL_FIXED_PERIOD_LO] =
               fixed_period_select;
            next_rd_data[core_timer_pkg::CTL_FIXED_IRQ_EN] = fixed_irq_enable;
            next_rd_data[core_timer_pkg::CTL_AUTO_RELOAD] = auto_reload;
         end
         core_timer_pkg::INTERVAL_TIMER_NUM: begin
            next_rd_data = programmable_interval_timer;
         end
         default: begin
            next_rd_data = core_timer_pkg::WORD_ZERO;
         end
      endcase
      next_watchdog_irq = watchdog_irq_pending && watchdog_irq_enable
         && crit_irq_enable;
      next_interval_irq = interval_irq_pending && interval_irq_enable
         && noncritical_irq_enable;
      next_fixed_irq = fixed_irq_pending && fixed_irq_enable
         && noncritical_irq_enable;
   end

   // Output registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= core_timer_pkg::WORD_ZERO;
         rd_valid <= 1'b0;
         watchdog_irq <= 1'b0;
         interval_irq <= 1'b0;
         fixed_irq <= 1'b0;
      end else begin
         rd_data <= reg_rd ? next_rd_data : core_timer_pkg::WORD_ZERO;
         rd_valid <= reg_rd;
         watchdog_irq <= next_watchdog_irq;
         interval_irq <= next_interval_irq;
         fixed_irq <= next_fixed_irq;
      end
   end

endmodule

// file: core_timer_chk.sv
// Port-level assertions for the timer and watchdog unit
`timescale 1ns/1ps
module core_timer_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register access
   input wire logic [9:0] reg_num,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic supervisor,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid,
   // Enables and event outputs
   input wire logic crit_irq_enable,
   input wire logic noncritical_irq_enable,
   input wire logic watchdog_irq,
   input wire logic interval_irq,
   input wire logic fixed_irq,
   input wire logic [1:0] watchdog_reset_req
);
   // All checks run on the core clock and pause in reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Every read is answered on the next edge, and only then
   rd_take_a: assert property (reg_rd |=> rd_valid)
      else $error("read request not answered next cycle");
   rd_quiet_a: assert property (!reg_rd |=> !rd_valid)
      else $error("read answer without a request");
   // Write-only time base numbers read back as zero
   low_wr_num_a: assert property (reg_rd && reg_num == 10'h11c |=> rd_data == 32'h0)
      else $error("low time base write number returned data");
   high_wr_num_a: assert property (reg_rd && reg_num == 10'h11d |=> rd_data == 32'h0)
      else $error("high time base write number returned data");
   // Control enables and periods read back what was written
   ctl_back_a: assert property ((reg_wr && supervisor && reg_num == 10'h3da) ##2
      (reg_rd && reg_num == 10'h3da) |=> {rd_data[31:30], rd_data[27:22]} ==
      {$past(reg_wdata[31:30], 3), $past(reg_wdata[27:22], 3)})
      else $error("control read back differs from write");
   // Interrupt lines only rise when their machine state enable allowed it
   wd_gate_a: assert property (watchdog_irq |-> $past(crit_irq_enable))
      else $error("watchdog interrupt with critical enable low");
   interval_gate_a: assert property (interval_irq |-> $past(noncritical_irq_enable))
      else $error("interval interrupt with noncritical enable low");
   fixed_gate_a: assert property (fixed_irq |-> $past(noncritical_irq_enable))
      else $error("fixed interrupt with noncritical enable low");
   // A forced reset request lasts one cycle
   reset_pulse_a: assert property (watchdog_reset_req != 2'h0 |=> watchdog_reset_req == 2'h0)
      else $error("watchdog reset request longer than one cycle");
endmodule

bind core_timer_watchdog_unit core_timer_chk chk (.core_clk(core_clk), .rst_n(rst_n),
   .reg_num(reg_num), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .supervisor(supervisor), .rd_data(rd_data), .rd_valid(rd_valid),
   .crit_irq_enable(crit_irq_enable), .noncritical_irq_enable(noncritical_irq_enable),
   .watchdog_irq(watchdog_irq), .interval_irq(interval_irq), .fixed_irq(fixed_irq),
   .watchdog_reset_req(watchdog_reset_req));

// file: tb.sv
// Self-checking bench for the timer and watchdog unit
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); end end
module tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] reg_num = 10'h0;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic supervisor = 1'b1;
   logic crit_irq_enable = 1'b1;
   logic noncritical_irq_enable = 1'b1;
   logic [31:0] rd_data;
   logic rd_valid;
   logic watchdog_irq;
   logic interval_irq;
   logic fixed_irq;
   logic [1:0] watchdog_reset_req;
   int error_cnt = 0;
   int tests_run = 0;
   logic [31:0] d;
   logic [31:0] e;

   core_timer_watchdog_unit dut (.core_clk(core_clk), .rst_n(rst_n), .reg_num(reg_num),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .supervisor(supervisor),
      .rd_data(rd_data), .rd_valid(rd_valid), .crit_irq_enable(crit_irq_enable),
      .noncritical_irq_enable(noncritical_irq_enable), .watchdog_irq(watchdog_irq),
      .interval_irq(interval_irq), .fixed_irq(fixed_irq),
      .watchdog_reset_req(watchdog_reset_req));

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   // One register write, privileged unless told otherwise
   task automatic wr(input logic [9:0] n, input logic [31:0] v, input logic s = 1'b1);
      @(negedge core_clk);
      reg_num = n;
      reg_wdata = v;
      supervisor = s;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      supervisor = 1'b1;
   endtask

   // One register read; the answer is settled by the next falling edge
   task automatic rd(input logic [9:0] n, output logic [31:0] v);
      @(negedge core_clk);
      reg_num = n;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      `CHK("rd_valid", 1'b1, rd_valid)
      v = rd_data;
   endtask

   // Reads status until a bit is set, giving up after a bounded count
   task automatic poll(input int b);
      int k;
      k = 0;
      d = 32'h0;
      while (d[b] !== 1'b1 && k < 40) begin
         rd(10'h3d8, d);
         k++;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Registers come out of reset cleared; the low write number and an unmapped number read as zero
   task automatic t_reset;
      rd(10'h3da, d);
      `CHK("control reset", 32'h0, d)
      rd(10'h3d8, d);
      `CHK("status reset", 32'h0, d)
      rd(10'h3db, d);
      `CHK("interval reset", 32'h0, d)
      rd(10'h11c, d);
      `CHK("low write number", 32'h0, d)
      rd(10'h3ff, d);
      `CHK("unmapped", 32'h0, d)
   endtask

   // Carry from low into high word, refused unprivileged write
   task automatic t_timebase;
      wr(10'h11d, 32'h5);
      wr(10'h11c, 32'hfffffff0);
      wr(10'h11d, 32'h77, 1'b0);
      idle(20);
      rd(10'h10d, d);
      `CHK("high word carry", 32'h6, d)
      rd(10'h10c, e);
      rd(10'h10c, d);
      `CHK("low word step", e + 32'h2, d)
      rd(10'h11d, d);
      `CHK("high write number", 32'h0, d)
   endtask

   // Reset kind can be set but never cleared by a write
   task automatic t_kind;
      wr(10'h3da, 32'h10000000);
      rd(10'h3da, d);
      `CHK("kind core", 32'h10000000, d)
      wr(10'h3da, 32'h20000000);
      rd(10'h3da, d);
      `CHK("kind sticky", 32'h30000000, d)
      wr(10'h3da, 32'h0);
      rd(10'h3da, d);
      `CHK("kind no clear", 32'h30000000, d)
   endtask

   // Every watchdog period, then escalation to interrupt and reset
   task automatic t_watchdog;
      int k;
      for (int c = 0; c < 4; c++) begin
         wr(10'h3da, (32'(c) << 30) | 32'h08000000);
         wr(10'h3d8, 32'hffffffff);
         wr(10'h11c, (32'h1 << (16 + 4 * c)) - 32'h8);
         rd(10'h3d8, d);
         `CHK("arm early", 1'b0, d[31])
         poll(31);
         `CHK("first event arms", 2'h2, d[31:30])
      end
      wr(10'h11c, 32'h0ffffff8);
      poll(30);
      `CHK("second event pends", 2'h3, d[31:30])
      idle(2);
      `CHK("watchdog irq", 1'b1, watchdog_irq)
      crit_irq_enable = 1'b0;
      idle(2);
      `CHK("watchdog irq masked", 1'b0, watchdog_irq)
      wr(10'h11c, 32'h0ffffff8);
      k = 0;
      while (watchdog_reset_req === 2'h0 && k < 40) begin
         idle(1);
         k++;
      end
      `CHK("reset request", 2'h3, watchdog_reset_req)
      rd(10'h3d8, d);
      `CHK("reset cause", 2'h3, d[29:28])
      wr(10'h3d8, 32'h40000000);
      rd(10'h3d8, d);
      `CHK("clear pending only", 4'hb, d[31:28])
      crit_irq_enable = 1'b1;
   endtask

   // Interval timer: expiry, gating, clear and auto reload
   task automatic t_interval;
      wr(10'h3da, 32'h04000000);
      wr(10'h3d8, 32'hffffffff);
      wr(10'h3db, 32'h3);
      poll(27);
      `CHK("interval pending", 1'b1, d[27])
      rd(10'h3db, d);
      `CHK("interval stopped", 32'h0, d)
      `CHK("interval irq", 1'b1, interval_irq)
      noncritical_irq_enable = 1'b0;
      idle(2);
      `CHK("interval irq masked", 1'b0, interval_irq)
      noncritical_irq_enable = 1'b1;
      wr(10'h3d8, 32'h08000000);
      rd(10'h3d8, d);
      `CHK("interval cleared", 1'b0, d[27])
      wr(10'h3da, 32'h0);
      wr(10'h3db, 32'h3);
      poll(27);
      `CHK("interval pending masked", 1'b1, d[27])
      idle(2);
      `CHK("interval irq disabled", 1'b0, interval_irq)
      wr(10'h3da, 32'h04400000);
      wr(10'h3d8, 32'h08000000);
      wr(10'h3db, 32'h6);
      poll(27);
      `CHK("interval first", 1'b1, d[27])
      // Only a reloaded count can raise the second event
      wr(10'h3d8, 32'h08000000);
      poll(27);
      `CHK("interval reloaded", 1'b1, d[27])
   endtask

   // Every fixed period with its interrupt enabled
   task automatic t_fixed;
      for (int c = 0; c < 4; c++) begin
         e = (32'(c) << 24) | 32'h00800000;
         wr(10'h3da, e);
         rd(10'h3da, d);
         `CHK("fixed control", e | 32'h30000000, d)
         wr(10'h3d8, 32'hffffffff);
         wr(10'h11c, (32'h1 << (8 + 4 * c)) - 32'h8);
         rd(10'h3d8, d);
         `CHK("fixed early", 1'b0, d[26])
         poll(26);
         `CHK("fixed pending", 1'b1, d[26])
         idle(1);
         `CHK("fixed irq", 1'b1, fixed_irq)
      end
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      t_reset();
      t_timebase();
      t_kind();
      t_watchdog();
      t_interval();
      t_fixed();
      print_verdict();
   end
endmodule
